/* File: core/kmw_pkg.sv */
/*
  Package for the keyboard/mouse wake and isolation block: register offsets,
  field positions, reset values and bus carrier structs.
  Assumes a single Avalon-MM slave with word-aligned byte addresses.
*/
package kmw_pkg;
  // ==========================================================================
  // register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam logic [7:0] KMW_KBC_RESET_CONFIG_OFS = 8'h2C;
  localparam logic [7:0] KMW_KBD_RESET_GATE_OFS = 8'hF0;
  localparam logic [7:0] KMW_WAKE_STATUS_OFS = 8'h40;
  localparam logic [7:0] KMW_WAKE_ENABLE_OFS = 8'h44;
  localparam logic [7:0] KMW_WAKE_CTRL_OFS = 8'h48;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int KMW_KBC_RESET_BIT = 6;
  localparam int KMW_MOUSE_ISO_BIT = 6;
  localparam int KMW_KBD_ISO_BIT = 5;
  localparam int KMW_GLOBAL_EN_BIT = 0;
  localparam int KMW_EV_KBD_INT = 0;
  localparam int KMW_EV_MOUSE_INT = 1;
  localparam int KMW_EV_KBD_DATA = 2;
  localparam int KMW_EV_MOUSE_DATA = 3;
  localparam int KMW_NUM_EVENTS = 4;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] KMW_KBC_RESET_CONFIG_RST = 8'h00;
  localparam logic [7:0] KMW_KBD_RESET_GATE_RST = 8'h00;
  localparam logic [3:0] KMW_WAKE_ENABLE_RST = 4'h0;
  localparam logic KMW_GLOBAL_EN_RST = 1'b0;
  localparam logic [31:0] KMW_UNMAPPED_READ = 32'h0000_0000;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } kmw_req_t;

  typedef struct packed {
    logic clk;
    logic data;
  } kmw_line_pair_t;

  typedef enum logic [1:0] {
    KMW_BUS_IDLE = 2'b00,
    KMW_BUS_ACK = 2'b01
  } kmw_bus_state_t;
endpackage

/* File: core/kmw_sync2.sv */
/*
  Two-flop level synchroniser, parameterised width.
  Assumes the input is asynchronous to clk_in; only the second stage is read.
*/
`timescale 1ns/10ps
module kmw_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= INIT;
      q_out <= INIT;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

/* File: core/kmw_edge_det.sv */
/*
  Link-domain falling-edge detector for the keyboard and mouse data lines.
  Each detected edge flips a toggle that the register domain picks up.
  Assumes link_clk_in runs on standby supply; lines idle high.
*/
`timescale 1ns/10ps
module kmw_edge_det #(
  parameter int WIDTH = 2
) (
  input wire logic link_clk_in,
  input wire logic link_arst_n_in,
  input wire logic [WIDTH-1:0] line_in,
  output logic [WIDTH-1:0] toggle_out
);
  logic [WIDTH-1:0] line_s;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] fall;

  kmw_sync2 #(
    .WIDTH(WIDTH),
    .INIT({WIDTH{1'b1}})
  ) u_sync (
    .clk_in(link_clk_in),
    .arst_n_in(link_arst_n_in),
    .d_in(line_in),
    .q_out(line_s)
  );

  assign fall = prev_q & ~line_s;

  always_ff @(posedge link_clk_in or negedge link_arst_n_in) begin
    if (!link_arst_n_in) begin
      prev_q <= {WIDTH{1'b1}};
      toggle_out <= '0;
    end else begin
      prev_q <= line_s;
      toggle_out <= toggle_out ^ fall;
    end
  end
endmodule

/* File: core/kmw_wake_top.sv */
/*
  Keyboard/mouse wake-event and isolation block with Avalon-MM register slave.
  Assumes a 200 MHz ref_clk_in for the register side and a separate link clock
  for the data-line edge logic, which stays alive on standby supply.
*/
// Function
// - four sticky wake bits: kbd/mouse int, data edges
// - wake out needs event, own enable, global enable
// - interrupt wake only on main supply
// - data edge wake on main or standby
// - isolation blocks controller, data still reach wake
// - bit 6 of gate control isolates mouse
// - bit 5 of gate control isolates keyboard
// - config bit 6 holds controller reset, no self-clear
`timescale 1ns/10ps
module kmw_wake_top
  import kmw_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic link_clk_in,
  input wire logic link_arst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic main_power_good_in,
  input wire logic kbd_int_in,
  input wire logic mouse_int_in,
  input wire logic keyboard_clock_line_in,
  input wire logic keyboard_data_line_in,
  input wire logic mouse_clock_line_in,
  input wire logic mouse_data_line_in,
  output logic kbc_keyboard_clock_out,
  output logic kbc_keyboard_data_out,
  output logic kbc_mouse_clock_out,
  output logic kbc_mouse_data_out,
  output logic kbc_reset_out,
  output logic wake_event_out
);
  // ==========================================================================
  // registers and state
  // ==========================================================================
  kmw_bus_state_t state_q;
  kmw_bus_state_t state_d;
  logic [7:0] kbc_cfg_q;
  logic [7:0] gate_ctrl_q;
  logic [KMW_NUM_EVENTS-1:0] status_q;
  logic [KMW_NUM_EVENTS-1:0] status_d;
  logic [KMW_NUM_EVENTS-1:0] enable_q;
  logic global_en_q;
  logic [1:0] int_prev_q;
  logic [1:0] tog_prev_q;
  logic [31:0] rdata_d;
  kmw_req_t req;

  // ==========================================================================
  // synchronisers for pins and the link-domain toggles
  // ==========================================================================
  logic [1:0] int_s;
  logic power_s;
  logic [3:0] lines_s;
  logic [1:0] tog_link;
  logic [1:0] tog_s;

  kmw_sync2 #(
    .WIDTH(7),
    .INIT(7'h0F)
  ) u_pin_sync (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .d_in({mouse_int_in, kbd_int_in, main_power_good_in, mouse_data_line_in,
           mouse_clock_line_in, keyboard_data_line_in, keyboard_clock_line_in}),
    .q_out({int_s, power_s, lines_s})
  );

  // data lines sampled on the standby-powered link clock
  kmw_edge_det #(
    .WIDTH(2)
  ) u_edge (
    .link_clk_in(link_clk_in),
    .link_arst_n_in(link_arst_n_in),
    .line_in({mouse_data_line_in, keyboard_data_line_in}),
    .toggle_out(tog_link)
  );

  // toggle crossing: one edge = one event
  kmw_sync2 #(
    .WIDTH(2),
    .INIT(2'h0)
  ) u_tog_sync (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .d_in(tog_link),
    .q_out(tog_s)
  );

  // ==========================================================================
  // bus decode
  // ==========================================================================
  assign req = '{read: avs_read_in, write: avs_write_in,
                 address: avs_address_in, writedata: avs_writedata_in};

  wire access = (req.read | req.write) && (state_q == KMW_BUS_IDLE);
  // write lands at the edge that shows waitrequest low, request still held
  wire wr_en = (state_q == KMW_BUS_ACK) & req.write & avs_byteenable_in[0];
  wire hit_cfg = req.address == KMW_KBC_RESET_CONFIG_OFS;
  wire hit_gate = req.address == KMW_KBD_RESET_GATE_OFS;
  wire hit_stat = req.address == KMW_WAKE_STATUS_OFS;
  wire hit_en = req.address == KMW_WAKE_ENABLE_OFS;
  wire hit_ctrl = req.address == KMW_WAKE_CTRL_OFS;
  wire [7:0] wbyte = req.writedata[7:0];

  always_comb begin
    case (state_q)
      KMW_BUS_IDLE: state_d = access ? KMW_BUS_ACK : KMW_BUS_IDLE;
      KMW_BUS_ACK: state_d = KMW_BUS_IDLE;
      default: state_d = KMW_BUS_IDLE;
    endcase
  end

  assign rdata_d = hit_cfg ? {24'h000000, kbc_cfg_q} :
                   hit_gate ? {24'h000000, gate_ctrl_q} :
                   hit_stat ? {28'h0000000, status_q} :
                   hit_en ? {28'h0000000, enable_q} :
                   hit_ctrl ? {31'h00000000, global_en_q} : KMW_UNMAPPED_READ;

  // ==========================================================================
  // wake events
  // ==========================================================================
  // interrupt events only while main supply is up
  wire [1:0] int_rise = int_s & ~int_prev_q & {2{power_s}};
  wire [1:0] data_ev = tog_s ^ tog_prev_q;
  wire [KMW_NUM_EVENTS-1:0] events = {data_ev, int_rise};
  wire [KMW_NUM_EVENTS-1:0] clr = (wr_en && hit_stat) ? wbyte[3:0] : 4'h0;

  // write-one-to-clear, but a new event wins over the clear
  assign status_d = (status_q & ~clr) | events;

  wire wake_d = global_en_q & (|(status_q & enable_q));

  // ==========================================================================
  // isolation toward the internal controller
  // ==========================================================================
  // isolated lines read as idle high; the wake path taps the pins directly
  wire kbd_iso = gate_ctrl_q[KMW_KBD_ISO_BIT];
  wire mouse_iso = gate_ctrl_q[KMW_MOUSE_ISO_BIT];

  // ==========================================================================
  // flops
  // ==========================================================================
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= KMW_BUS_IDLE;
      kbc_cfg_q <= KMW_KBC_RESET_CONFIG_RST;
      gate_ctrl_q <= KMW_KBD_RESET_GATE_RST;
      enable_q <= KMW_WAKE_ENABLE_RST;
      global_en_q <= KMW_GLOBAL_EN_RST;
      status_q <= '0;
      int_prev_q <= 2'h0;
      tog_prev_q <= 2'h0;
      avs_readdata_out <= KMW_UNMAPPED_READ;
      wake_event_out <= 1'b0;
      kbc_reset_out <= 1'b0;
      kbc_keyboard_clock_out <= 1'b1;
      kbc_keyboard_data_out <= 1'b1;
      kbc_mouse_clock_out <= 1'b1;
      kbc_mouse_data_out <= 1'b1;
    end else begin
      state_q <= state_d;
      // held until software writes it back
      if (wr_en && hit_cfg) begin
        kbc_cfg_q <= wbyte;
      end
      if (wr_en && hit_gate) begin
        gate_ctrl_q <= wbyte;
      end
      if (wr_en && hit_en) begin
        enable_q <= wbyte[3:0];
      end
      if (wr_en && hit_ctrl) begin
        global_en_q <= wbyte[KMW_GLOBAL_EN_BIT];
      end
      status_q <= status_d;
      int_prev_q <= int_s;
      tog_prev_q <= tog_s;
      if (access) begin
        avs_readdata_out <= rdata_d;
      end
      wake_event_out <= wake_d;
      kbc_reset_out <= kbc_cfg_q[KMW_KBC_RESET_BIT];
      kbc_keyboard_clock_out <= lines_s[0] | kbd_iso;
      kbc_keyboard_data_out <= lines_s[1] | kbd_iso;
      kbc_mouse_clock_out <= lines_s[2] | mouse_iso;
      kbc_mouse_data_out <= lines_s[3] | mouse_iso;
    end
  end

  // waitrequest high except in the answer cycle
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      avs_waitrequest_out <= 1'b1;
    end else begin
      avs_waitrequest_out <= !(state_d == KMW_BUS_ACK);
    end
  end
endmodule

/* File: test/kmw_wake_props.sv */
/* checker: config reset, isolation and wake gating of kmw_wake_top
   assumes it is bound onto kmw_wake_top; one reference clock domain */
`timescale 1ns/10ps
module kmw_wake_props
  import kmw_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic mouse_data_line_in,
  input wire logic kbc_keyboard_data_out,
  input wire logic kbc_mouse_clock_out,
  input wire logic kbc_mouse_data_out,
  input wire logic kbc_reset_out,
  input wire logic wake_event_out
);
  // ========================================
  // shadow of the written control bits
  logic [7:0] iso_q;
  logic glob_q;
  wire logic wr_ok = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  wire logic cfg_wr = wr_ok & (avs_address_in == KMW_KBC_RESET_CONFIG_OFS);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      iso_q <= 8'h00;
      glob_q <= 1'b0;
    end else if (wr_ok) begin
      if (avs_address_in == KMW_KBD_RESET_GATE_OFS) iso_q <= avs_writedata_in[7:0];
      if (avs_address_in == KMW_WAKE_CTRL_OFS) glob_q <= avs_writedata_in[0];
    end
  end
  // ========================================
  // properties
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  property cfg_follow_p;
    cfg_wr |-> ##2 kbc_reset_out == $past(avs_writedata_in[6], 2);
  endproperty
  cfg_reset_a: assert property (cfg_follow_p)
    else $error("controller reset not following config");
  cfg_hold_a: assert property (
    $changed(kbc_reset_out) |-> $past(cfg_wr) || $past(cfg_wr, 2))
    else $error("controller reset moved without a write");
  // four cycles of history: forcing may sit anywhere in the sync chain
  mouse_block_a: assert property (iso_q[6] && $past(iso_q[6], 4) |-> kbc_mouse_data_out)
    else $error("mouse data reached controller while isolated");
  mclk_block_a: assert property (iso_q[6] && $past(iso_q[6], 4) |-> kbc_mouse_clock_out)
    else $error("mouse clock reached controller while isolated");
  kbd_block_a: assert property (iso_q[5] && $past(iso_q[5], 4) |-> kbc_keyboard_data_out)
    else $error("keyboard data reached controller while isolated");
  mouse_pass_a: assert property (
    !iso_q[6] && !$past(iso_q[6], 4) |-> kbc_mouse_data_out == $past(mouse_data_line_in, 3))
    else $error("mouse data not passed through");
  wake_gate_a: assert property (!glob_q && !$past(glob_q) |-> !wake_event_out)
    else $error("wake out with global enable off");
  wake_rise_a: assert property ($rose(wake_event_out) |-> $past(glob_q))
    else $error("wake rose with global enable off");
  cover property (cfg_wr && avs_writedata_in[6]);
  cover property ($rose(wake_event_out));
  cover property (iso_q[5] && $fell(mouse_data_line_in));
endmodule

bind kmw_wake_top kmw_wake_props u_props (
  .ref_clk_in(ref_clk_in),
  .arst_n_in(arst_n_in),
  .avs_address_in(avs_address_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .mouse_data_line_in(mouse_data_line_in),
  .kbc_keyboard_data_out(kbc_keyboard_data_out),
  .kbc_mouse_clock_out(kbc_mouse_clock_out),
  .kbc_mouse_data_out(kbc_mouse_data_out),
  .kbc_reset_out(kbc_reset_out),
  .wake_event_out(wake_event_out)
);

/* File: test/kmw_far_model.sv */
/* far-side model: keyboard, mouse and the controller's interrupt lines
   assumes a free-running link clock; idle lines sit high on pull-ups */
`timescale 1ns/10ps
module kmw_far_model (
  input wire logic link_clk_in,
  output logic kbd_int_out,
  output logic mouse_int_out,
  output logic keyboard_clock_line_out,
  output logic keyboard_data_line_out,
  output logic mouse_clock_line_out,
  output logic mouse_data_line_out
);
  logic [3:0] act_q = 4'h0;
  assign kbd_int_out = act_q[0];
  assign mouse_int_out = act_q[1];
  // clock stands still high between frames; pull-up restores data
  assign keyboard_clock_line_out = ~act_q[2];
  assign keyboard_data_line_out = ~act_q[2];
  assign mouse_clock_line_out = ~act_q[3];
  assign mouse_data_line_out = ~act_q[3];
  // 0 kbd int, 1 mouse int, 2 kbd data, 3 mouse data
  task automatic fire(input int i);
    @(posedge link_clk_in);
    act_q[i] <= 1'b1;
    repeat (10) @(posedge link_clk_in);
    act_q[i] <= 1'b0;
  endtask
endmodule

/* File: test/tb.sv */
/* testbench for kmw_wake_top: register traffic, wake events, isolation
   assumes kmw_pkg, the far-side model and the bound checker */
`timescale 1ns/10ps
module tb;
  import kmw_pkg::*;
  logic ref_clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic main_power_good_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out, seed = 32'h5, v;
  logic avs_waitrequest_out, kbd_int_in, mouse_int_in, wake_event_out, kbc_reset_out;
  logic keyboard_clock_line_in, keyboard_data_line_in, mouse_clock_line_in, mouse_data_line_in;
  logic kbc_keyboard_clock_out, kbc_keyboard_data_out, kbc_mouse_clock_out, kbc_mouse_data_out;
  logic [7:0] ofs [6] = '{8'h2C, 8'hF0, 8'h40, 8'h44, 8'h48, 8'h10};
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  always #2.5 ref_clk_in = ~ref_clk_in;
  // offset keeps link edges clear of reference edges
  initial begin
    #1.3;
    forever #15 link_clk_in = ~link_clk_in;
  end
  kmw_wake_top DUT (
    .ref_clk_in, .arst_n_in, .link_clk_in, .link_arst_n_in(arst_n_in),
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .main_power_good_in, .kbd_int_in, .mouse_int_in, .keyboard_clock_line_in,
    .keyboard_data_line_in, .mouse_clock_line_in, .mouse_data_line_in,
    .kbc_keyboard_clock_out, .kbc_keyboard_data_out, .kbc_mouse_clock_out,
    .kbc_mouse_data_out, .kbc_reset_out, .wake_event_out);
  kmw_far_model u_far (
    .link_clk_in, .kbd_int_out(kbd_int_in), .mouse_int_out(mouse_int_in),
    .keyboard_clock_line_out(keyboard_clock_line_in),
    .keyboard_data_line_out(keyboard_data_line_in),
    .mouse_clock_line_out(mouse_clock_line_in), .mouse_data_line_out(mouse_data_line_in));
  // ========================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic exp_wake(input logic [3:0] st, input logic [4:0] en);
    return (|(st & en[3:0])) & en[4];
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    avs_read_in <= !w;
    avs_write_in <= w;
    avs_address_in <= a;
    avs_writedata_in <= d;
    do @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0);
    v = w ? v : avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] keep;
    keep = v;
    bus(1'b0, a, 32'h0);
    chk("readback", e, v);
    v = keep;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ========================================
  // scenarios
  initial begin
    repeat (8) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    foreach (ofs[i]) rchk(ofs[i], 32'h0);
    $display("test reset values done");
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        v = j ? xs() : 32'h1F;
        bus(1'b1, 8'h44, {28'h0, v[3:0]});
        bus(1'b1, 8'h48, {31'h0, v[4]});
        u_far.fire(i);
        repeat (30) @(posedge ref_clk_in);
        rchk(8'h40, 32'h1 << i);
        chk("wake", exp_wake(4'h1 << i, v[4:0]), wake_event_out);
        bus(1'b1, 8'h40, 32'h1 << i);
        rchk(8'h40, 32'h0);
      end
    end
    $display("test wake events done");
    bus(1'b1, 8'hF0, 32'h60);
    main_power_good_in <= 1'b0;
    repeat (10) @(posedge ref_clk_in);
    for (int i = 0; i < 4; i++) u_far.fire(i);
    repeat (30) @(posedge ref_clk_in);
    rchk(8'h40, 32'hC);
    bus(1'b1, 8'h40, 32'hF);
    main_power_good_in <= 1'b1;
    $display("test standby done");
    for (int k = 1; k >= 0; k--) begin
      bus(1'b1, 8'hF0, k ? 32'h60 : 32'h0);
      fork
        u_far.fire(2);
        u_far.fire(3);
        begin
          repeat (40) @(posedge ref_clk_in);
          chk("kbc data", k, kbc_keyboard_data_out);
          chk("kbc clock", k, kbc_keyboard_clock_out);
          chk("kbc mouse data", k, kbc_mouse_data_out);
          chk("kbc mouse clock", k, kbc_mouse_clock_out);
          rchk(8'h40, 32'hC);
          bus(1'b1, 8'h40, 32'hC);
        end
      join
      repeat (30) @(posedge ref_clk_in);
      rchk(8'h40, 32'h0);
    end
    $display("test isolation done");
    bus(1'b1, 8'h2C, 32'h40);
    repeat (20) @(posedge ref_clk_in);
    chk("kbc reset", 1, kbc_reset_out);
    avs_byteenable_in <= 4'h0;
    bus(1'b1, 8'h2C, 32'h0);
    avs_byteenable_in <= 4'hF;
    rchk(8'h2C, 32'h40);
    bus(1'b1, 8'h2C, 32'h0);
    rchk(8'h2C, 32'h0);
    chk("kbc reset", 0, kbc_reset_out);
    $display("test controller reset done");
    for (int i = 0; i < 20; i++) begin
      v = xs();
      bus(1'b1, 8'hF0, v);
      rchk(8'hF0, {24'h0, v[7:0]});
      bus(1'b1, {3'h0, v[12:10], 2'h0}, v);
      rchk({3'h0, v[12:10], 2'h0}, 32'h0);
    end
    $display("test random registers done");
    conclude();
  end
endmodule
